// file: hw/adcctl_top.sv
// Summary of operation
// - Reference field picks external, supply or internal
// - Channel/reference writes apply after current conversion
// - Alignment bit selects left or right result
// - Alignment change alters readback immediately
// - Channel codes 0-7 select single inputs
// - Codes 8-29 select differential pairs and gain
// - Code 30 bandgap, code 31 ground
// - Enable powers up; clearing aborts conversion
// - Start begins single or first free-running conversion
// - First conversion 25 clocks, later 13
// - Start reads one while converting; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag set at every conversion end, even while a locked result is not updated
// - Interrupt needs flag, enable and global enable, or status and its own enable
// - Flag cleared by vector or writing one
// - Divider field sets converter clock ratio
// - Bit 3 enables interrupt, gated globally
// - Low byte read locks result until high
`timescale 1ns/1ps
`default_nettype none
module adcctl_top
  import adcctl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Avalon-MM slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Trigger sources, one per trigger select code
  input wire logic [7:0] i_trigger_sources,
  // Interrupt vector acknowledge
  input wire logic i_irq_vector_ack,
  // Analog core: conversion answer
  input wire logic [9:0] i_core_result,
  // Analog core controls
  output logic o_core_power,
  output logic o_core_sample,
  output logic [2:0] o_core_pos_input,
  output logic [2:0] o_core_neg_input,
  output logic o_core_differential,
  output logic [1:0] o_core_gain,
  output logic [1:0] o_core_source,
  output logic [1:0] o_core_reference,
  output logic o_core_internal_ref_on,
  output logic o_core_result_undefined,
  output logic o_core_conv_clk,
  // Interrupt
  output logic o_irq
);

  // Software registers
  logic [7:0] chan_ref_sw; // Channel/reference as written
  logic [7:0] chan_ref_act; // Setting in use by the converter
  logic enable;
  logic start;
  logic auto_trig;
  logic done_flag;
  logic done_ie;
  logic [2:0] divider;
  logic [2:0] trig_sel;
  logic global_ie;
  logic irq_status;
  logic irq_enable;
  // Result storage
  logic [9:0] result;
  logic result_locked;
  // Converter clock prescaler
  logic [6:0] presc;
  logic conv_tick;
  // Conversion sequencer
  logic [4:0] cycle_cnt;
  logic first_pending;
  logic trig_prev;
  logic trig_edge;
  logic conv_finish;
  logic conv_begin;
  // Bus access
  logic bus_write;
  logic bus_read;
  logic [3:0] word_idx;
  logic [7:0] wbyte;
  logic [7:0] next_readdata;
  logic [7:0] chan_ref_next_act;
  // Terminal prescaler count for the selected ratio
  logic [6:0] div_last;
  // Software start written together with or after enable
  logic sw_start;
  // Free running rolls into the next conversion
  logic free_restart;

  // Divider ratio as terminal prescaler count
  function automatic logic [6:0] adcctl_div_last(input logic [2:0] sel);
    logic [7:0] ratio;
    ratio = 8'h00;
    if (sel == 3'h0)
    begin
      ratio = 8'h02;
    end
    else
    begin
      ratio = 8'h01 << sel;
    end
    adcctl_div_last = 7'(ratio - 8'h01);
  endfunction

  // Single wait cycle: waitrequest low on second request cycle
  assign bus_write = i_avs_write & o_avs_waitrequest == 1'b0;
  assign bus_read = i_avs_read & o_avs_waitrequest == 1'b0;
  assign word_idx = i_avs_address[5:2];
  assign wbyte = i_avs_writedata[7:0];

  // Waitrequest pulses low one cycle after a request appears
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_avs_waitrequest <= 1'b1;
    end
    else if ((i_avs_read | i_avs_write) & o_avs_waitrequest)
    begin
      o_avs_waitrequest <= 1'b0;
    end
    else
    begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Prescaler tick forms the converter clock
  // divider ratio
  assign div_last = adcctl_div_last(divider);
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      presc <= 7'h00;
      o_core_conv_clk <= 1'b0;
    end
    else if (!enable)
    begin
      presc <= 7'h00;
      o_core_conv_clk <= 1'b0;
    end
    else if (presc >= div_last)
    begin
      presc <= 7'h00;
      o_core_conv_clk <= 1'b0;
    end
    else
    begin
      presc <= presc + 7'h01;
      o_core_conv_clk <= (presc + 7'h01) >= {1'b0, div_last[6:1]} + 7'h01;
    end
  end
  assign conv_tick = enable & (presc >= div_last);

  // Trigger edge detect on the selected source
  // rising edge
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      trig_prev <= 1'b0;
    end
    else
    begin
      trig_prev <= i_trigger_sources[trig_sel];
    end
  end
  assign trig_edge = i_trigger_sources[trig_sel] & !trig_prev & (trig_sel != ADCCTL_TRIG_FREE_RUN);

  // End of conversion on the last converter clock
  assign conv_finish = start & conv_tick & (cycle_cnt == 5'd1);
  // New conversion request from software or a trigger edge; free run restarts separately
  // start request
  // A start written in the same access as enable must count as well
  assign sw_start = bus_write & word_idx == ADCCTL_IDX_CONTROL_STATUS &
    wbyte[ADCCTL_BIT_START] & wbyte[ADCCTL_BIT_ENABLE];
  assign conv_begin = !start & (sw_start | (enable & auto_trig & trig_edge));
  // Restart at completion; start is still high here, so it bypasses conv_begin
  assign free_restart = conv_finish & auto_trig & (trig_sel == ADCCTL_TRIG_FREE_RUN);

  // Enable bit tracking and first-conversion marker
  // enable and abort
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      enable <= 1'b0;
      first_pending <= 1'b1;
    end
    else
    begin
      if (bus_write & word_idx == ADCCTL_IDX_CONTROL_STATUS)
      begin
        enable <= wbyte[ADCCTL_BIT_ENABLE];
        if (!wbyte[ADCCTL_BIT_ENABLE])
        begin
          first_pending <= 1'b1;
        end
      end
      if (conv_finish)
      begin
        first_pending <= 1'b0;
      end
    end
  end

  // Conversion sequencer: start bit and cycle counter
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      start <= 1'b0;
      cycle_cnt <= 5'd0;
    end
    else if (bus_write & word_idx == ADCCTL_IDX_CONTROL_STATUS & !wbyte[ADCCTL_BIT_ENABLE])
    begin
      // Abort: the running conversion is dropped
      start <= 1'b0;
      cycle_cnt <= 5'd0;
    end
    else if (conv_begin & !conv_finish)
    begin
      start <= 1'b1;
      cycle_cnt <= first_pending ? ADCCTL_FIRST_CYCLES : ADCCTL_NORMAL_CYCLES;
    end
    else if (conv_finish)
    begin
      // Free running rolls straight into the next conversion
      start <= free_restart;
      cycle_cnt <= free_restart ? ADCCTL_NORMAL_CYCLES : 5'd0;
    end
    else if (start & conv_tick)
    begin
      cycle_cnt <= cycle_cnt - 5'd1;
    end
  end

  // Other control/status fields
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      auto_trig <= 1'b0;
      done_ie <= 1'b0;
      divider <= 3'h0;
      trig_sel <= 3'h0;
      global_ie <= 1'b0;
      irq_enable <= 1'b0;
    end
    else if (bus_write)
    begin
      if (word_idx == ADCCTL_IDX_CONTROL_STATUS)
      begin
        auto_trig <= wbyte[ADCCTL_BIT_AUTO];
        done_ie <= wbyte[ADCCTL_BIT_IE];
        divider <= wbyte[2:0];
      end
      if (word_idx == ADCCTL_IDX_TRIGGER_SELECT)
      begin
        trig_sel <= wbyte[2:0];
      end
      if (word_idx == ADCCTL_IDX_GLOBAL_IE)
      begin
        global_ie <= wbyte[0];
      end
      if (word_idx == ADCCTL_IDX_IRQ_ENABLE)
      begin
        irq_enable <= wbyte[0];
      end
    end
  end

  // Done flag: set wins over vector or write-one clear
  // flag with result
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      done_flag <= 1'b0;
      irq_status <= 1'b0;
    end
    else
    begin
      if (conv_finish)
      begin
        done_flag <= 1'b1;
      end
      else if (i_irq_vector_ack |
               (bus_write & word_idx == ADCCTL_IDX_CONTROL_STATUS & wbyte[ADCCTL_BIT_DONE]))
      begin
        done_flag <= 1'b0;
      end
      if (conv_finish)
      begin
        irq_status <= 1'b1;
      end
      else if (bus_write & word_idx == ADCCTL_IDX_IRQ_CLEAR & wbyte[0])
      begin
        irq_status <= 1'b0;
      end
    end
  end

  // Interrupt output
  // three-way gate
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= (done_flag & done_ie & global_ie) | (irq_status & irq_enable);
    end
  end

  // Channel/reference register and deferred active copy
  // deferred apply
  always_comb
  begin
    chan_ref_next_act = chan_ref_act;
    if (!start | conv_finish)
    begin
      chan_ref_next_act = chan_ref_sw;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      chan_ref_sw <= ADCCTL_RESET_BYTE;
      chan_ref_act <= ADCCTL_RESET_BYTE;
    end
    else
    begin
      if (bus_write & word_idx == ADCCTL_IDX_CHANNEL_REF)
      begin
        chan_ref_sw <= wbyte;
      end
      chan_ref_act <= chan_ref_next_act;
    end
  end

  // Result capture and low-then-high read lock
  // result lock
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      result <= 10'h000;
      result_locked <= 1'b0;
    end
    else
    begin
      if (conv_finish & !result_locked)
      begin
        result <= i_core_result;
      end
      if (bus_read & word_idx == ADCCTL_IDX_RESULT_LOW)
      begin
        result_locked <= 1'b1;
      end
      else if (bus_read & word_idx == ADCCTL_IDX_RESULT_HIGH)
      begin
        result_locked <= 1'b0;
      end
    end
  end

  // Read mux with immediate alignment
  always_comb
  begin
    next_readdata = 8'h00;
    unique case (word_idx)
      ADCCTL_IDX_RESULT_LOW:
        next_readdata = chan_ref_sw[5] ? {result[1:0], 6'h00} : result[7:0];
      ADCCTL_IDX_RESULT_HIGH:
        next_readdata = chan_ref_sw[5] ? result[9:2] : {6'h00, result[9:8]};
      ADCCTL_IDX_CONTROL_STATUS:
        next_readdata = {enable, start, auto_trig, done_flag, done_ie, divider};
      ADCCTL_IDX_CHANNEL_REF:
        next_readdata = chan_ref_sw;
      ADCCTL_IDX_TRIGGER_SELECT:
        next_readdata = {5'h00, trig_sel};
      ADCCTL_IDX_IRQ_STATUS:
        next_readdata = {7'h00, irq_status};
      ADCCTL_IDX_IRQ_ENABLE:
        next_readdata = {7'h00, irq_enable};
      ADCCTL_IDX_GLOBAL_IE:
        next_readdata = {7'h00, global_ie};
      default:
        next_readdata = 8'h00;
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_avs_readdata <= 32'h00000000;
    end
    else if (i_avs_read & o_avs_waitrequest)
    begin
      o_avs_readdata <= {24'h000000, next_readdata};
    end
  end

  // Analog core controls from the active setting
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_core_power <= 1'b0;
      o_core_sample <= 1'b0;
      o_core_pos_input <= 3'h0;
      o_core_neg_input <= 3'h0;
      o_core_differential <= 1'b0;
      o_core_gain <= ADCCTL_GAIN_1X;
      o_core_source <= ADCCTL_SRC_PIN;
      o_core_reference <= ADCCTL_REF_EXTERNAL;
      o_core_internal_ref_on <= 1'b0;
      o_core_result_undefined <= 1'b0;
    end
    else
    begin
      o_core_power <= enable;
      o_core_sample <= start;
      o_core_reference <= chan_ref_next_act[7:6];
      o_core_internal_ref_on <= chan_ref_next_act[7:6] == ADCCTL_REF_INTERNAL;
      o_core_result_undefined <= chan_ref_next_act[7:6] == ADCCTL_REF_RESERVED;
      o_core_source <= ADCCTL_SRC_PIN;
      o_core_gain <= ADCCTL_GAIN_1X;
      o_core_differential <= 1'b1;
      o_core_pos_input <= chan_ref_next_act[2:0];
      o_core_neg_input <= 3'h0;
      unique case (chan_ref_next_act[4:3])
        2'b00:
        begin
          o_core_differential <= 1'b0;
        end
        2'b01:
        begin
          o_core_pos_input <= {1'b0, chan_ref_next_act[2], chan_ref_next_act[0]};
          o_core_neg_input <= {1'b0, chan_ref_next_act[2], 1'b0};
          o_core_gain <= chan_ref_next_act[1] ? ADCCTL_GAIN_200X : ADCCTL_GAIN_10X;
        end
        2'b10:
        begin
          o_core_neg_input <= 3'h1;
        end
        default:
        begin
          o_core_neg_input <= 3'h2;
          if (chan_ref_next_act[2:0] == 3'h6)
          begin
            o_core_differential <= 1'b0;
            o_core_source <= ADCCTL_SRC_BANDGAP;
          end
          else if (chan_ref_next_act[2:0] == 3'h7)
          begin
            o_core_differential <= 1'b0;
            o_core_source <= ADCCTL_SRC_GROUND;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: hw/adcctl_pkg.sv
package adcctl_pkg;
  // Register word offsets (byte addresses are four times these)
  localparam logic [3:0] ADCCTL_IDX_RESULT_LOW = 4'h4;
  localparam logic [3:0] ADCCTL_IDX_RESULT_HIGH = 4'h5;
  localparam logic [3:0] ADCCTL_IDX_CONTROL_STATUS = 4'h6;
  localparam logic [3:0] ADCCTL_IDX_CHANNEL_REF = 4'h7;
  localparam logic [3:0] ADCCTL_IDX_TRIGGER_SELECT = 4'h8;
  localparam logic [3:0] ADCCTL_IDX_IRQ_STATUS = 4'h9;
  localparam logic [3:0] ADCCTL_IDX_IRQ_ENABLE = 4'hA;
  localparam logic [3:0] ADCCTL_IDX_IRQ_CLEAR = 4'hB;
  localparam logic [3:0] ADCCTL_IDX_GLOBAL_IE = 4'hC;
  // Control/status bit positions
  localparam int ADCCTL_BIT_ENABLE = 7;
  localparam int ADCCTL_BIT_START = 6;
  localparam int ADCCTL_BIT_AUTO = 5;
  localparam int ADCCTL_BIT_DONE = 4;
  localparam int ADCCTL_BIT_IE = 3;
  // Reset values
  localparam logic [7:0] ADCCTL_RESET_BYTE = 8'h00;
  // Conversion lengths in converter clocks
  localparam logic [4:0] ADCCTL_FIRST_CYCLES = 5'd25;
  localparam logic [4:0] ADCCTL_NORMAL_CYCLES = 5'd13;
  // Reference codes
  localparam logic [1:0] ADCCTL_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ADCCTL_REF_SUPPLY = 2'h1;
  localparam logic [1:0] ADCCTL_REF_RESERVED = 2'h2;
  localparam logic [1:0] ADCCTL_REF_INTERNAL = 2'h3;
  // Trigger source zero means free running
  localparam logic [2:0] ADCCTL_TRIG_FREE_RUN = 3'h0;
  // Gain encodings presented to the analog core
  localparam logic [1:0] ADCCTL_GAIN_1X = 2'h0;
  localparam logic [1:0] ADCCTL_GAIN_10X = 2'h1;
  localparam logic [1:0] ADCCTL_GAIN_200X = 2'h2;
  // Special input selections
  localparam logic [1:0] ADCCTL_SRC_PIN = 2'h0;
  localparam logic [1:0] ADCCTL_SRC_BANDGAP = 2'h1;
  localparam logic [1:0] ADCCTL_SRC_GROUND = 2'h2;
endpackage

// file: verif/adcctl_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcctl_core_model
(
  // Conversion in progress
  input wire logic i_sample,
  // Value the bench wants converted
  input wire logic [9:0] i_value,
  // Result handed back to the block
  output logic [9:0] o_result
);
  // Outside a conversion the answer is scrambled, so a stale capture shows
  assign o_result = i_sample ? i_value : ~i_value;
endmodule
`default_nettype wire

// file: verif/adcctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adcctl_asserts
(
  // Clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Core controls
  input wire logic o_core_power,
  input wire logic o_core_sample,
  input wire logic [2:0] o_core_pos_input,
  input wire logic o_core_differential,
  input wire logic [1:0] o_core_gain,
  input wire logic [1:0] o_core_source,
  input wire logic [1:0] o_core_reference,
  input wire logic o_core_internal_ref_on,
  input wire logic o_core_result_undefined,
  input wire logic o_core_conv_clk
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Core clocks spent in the running conversion
  logic [11:0] run_len;
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      run_len <= 12'h000;
    else if (o_core_sample)
      run_len <= run_len + 12'h001;
    else
      run_len <= 12'h000;
  end
  // One wait cycle, then idle again
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_answer;
    $rose(i_avs_read || i_avs_write) |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_rd_upper;
    !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_abort;
    $fell(o_core_power) |-> ##[0:2] !o_core_sample;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");
  property p_clk_off;
    !o_core_power [*2] |-> !o_core_conv_clk;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("converter clock runs off");
  property p_hold_ref;
    $changed(o_core_reference) && o_core_sample |=> !o_core_sample;
  endproperty
  a_hold_ref: assert property (p_hold_ref) else $error("reference changed mid run");
  property p_hold_mux;
    $changed(o_core_pos_input) && o_core_sample |=> !o_core_sample;
  endproperty
  a_hold_mux: assert property (p_hold_mux) else $error("channel changed mid run");
  property p_min_len;
    $fell(o_core_sample) && o_core_power |-> run_len >= 12'h018;
  endproperty
  a_min_len: assert property (p_min_len) else $error("conversion too short");
  property p_int_ref;
    o_core_internal_ref_on == (o_core_reference == 2'h3);
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("internal reference wrong");
  property p_undef;
    o_core_result_undefined == (o_core_reference == 2'h2);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined flag wrong");
  property p_gain;
    o_core_gain != 2'h0 |-> o_core_differential && o_core_source == 2'h0;
  endproperty
  a_gain: assert property (p_gain) else $error("gain on single input");
  property p_special;
    o_core_source != 2'h0 |-> !o_core_differential;
  endproperty
  a_special: assert property (p_special) else $error("special input differential");
endmodule
bind adcctl_top adcctl_asserts u_chk (.i_core_clk, .i_reset_n, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .o_core_power, .o_core_sample, .o_core_pos_input,
  .o_core_differential, .o_core_gain, .o_core_source, .o_core_reference,
  .o_core_internal_ref_on, .o_core_result_undefined, .o_core_conv_clk);
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcctl_pkg::*;
  // Driven by the bench
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [7:0] trig = 8'h00;
  logic ack = 1'b0;
  logic [9:0] val = 10'h2A7;
  // Seen from the block
  logic [31:0] rdata;
  logic wreq, pwr, smp, diff, iref, undef, cclk, irq;
  logic [2:0] pos, neg;
  logic [1:0] gain, src, refsel;
  logic [9:0] res;
  logic [7:0] q;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int hi = 0;
  int last = 0;
  always #20 i_core_clk = ~i_core_clk;
  adcctl_top u_dut (.i_core_clk, .i_reset_n, .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_trigger_sources(trig), .i_irq_vector_ack(ack), .i_core_result(res), .o_core_power(pwr),
    .o_core_sample(smp), .o_core_pos_input(pos), .o_core_neg_input(neg),
    .o_core_differential(diff), .o_core_gain(gain), .o_core_source(src),
    .o_core_reference(refsel), .o_core_internal_ref_on(iref), .o_core_result_undefined(undef),
    .o_core_conv_clk(cclk), .o_irq(irq));
  adcctl_core_model u_core (.i_sample(smp), .i_value(val), .o_result(res));
  // Run length of each conversion and the hang guard
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (smp === 1'b1)
      hi <= hi + 1;
    else if (hi != 0)
    begin
      last <= hi;
      hi <= 0;
    end
    if (cyc == 3000)
    begin
      n_fail++;
      summarize();
    end
  end
  // Expected {source, differential, gain, positive, negative} per channel code
  function automatic logic [10:0] mux_exp(input logic [4:0] c);
    if (c < 5'h08)
      return {2'h0, 1'b0, 2'h0, c[2:0], 3'h0};
    if (c < 5'h10)
      return {2'h0, 1'b1, c[1] ? 2'h2 : 2'h1, 1'b0, c[2], c[0], 1'b0, c[2], 1'b0};
    if (c < 5'h18)
      return {2'h0, 1'b1, 2'h0, c[2:0], 3'h1};
    if (c < 5'h1E)
      return {2'h0, 1'b1, 2'h0, c[2:0], 3'h2};
    return {c[0] ? 2'h2 : 2'h1, 1'b0, 2'h0, 3'h0, 3'h0};
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [3:0] idx, input logic w, input logic [7:0] d);
    @(posedge i_core_clk);
    adr <= {idx, 2'h0};
    rd <= ~w;
    wr <= w;
    wd <= {24'h000000, d};
    @(posedge i_core_clk);
    while (wreq !== 1'b0)
      @(posedge i_core_clk);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic w8(input logic [3:0] i, input logic [7:0] d);
    bus(i, 1'b1, d);
  endtask
  task automatic r8(input logic [3:0] i, input logic [7:0] e);
    bus(i, 1'b0, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Until the running conversion has ended
  task automatic waitdone;
    while (smp !== 1'b1)
      @(posedge i_core_clk);
    while (smp !== 1'b0)
      @(posedge i_core_clk);
    pause(2);
  endtask
  task automatic waitirq;
    while (irq !== 1'b1)
      @(posedge i_core_clk);
  endtask
  // Run length in core clocks for n converter clocks at ratio k
  task automatic chklen(input int n, input int k);
    chk({15'h0000, last >= k * (n - 1) + 1 && last <= k * n}, 16'h0001);
  endtask
  initial
  begin
    pause(2);
    i_reset_n <= 1'b1;
    r8(4'h6, 8'h00);
    r8(4'h7, 8'h00);
    w8(4'hF, 8'h5A);
    r8(4'hF, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 32; c++)
    begin
      w8(4'h7, c[7:0]);
      pause(2);
      chk({5'h00, src, diff, gain, src == 2'h0 ? pos : 3'h0, diff ? neg : 3'h0},
        {5'h00, mux_exp(c[4:0])});
    end
    for (int r = 0; r < 4; r++)
    begin
      w8(4'h7, {r[1:0], 6'h00});
      pause(2);
      chk({12'h000, refsel, iref, undef}, {12'h000, r[1:0], r == 3, r == 2});
    end
    $display("test selection done");
    w8(4'h7, 8'h00);
    w8(4'h6, 8'hC2);
    r8(4'h6, 8'hC2);
    w8(4'h7, 8'h05);
    pause(2);
    chk({12'h000, pwr, pos}, 16'h0008);
    w8(4'h6, 8'h82);
    r8(4'h6, 8'hC2);
    waitdone();
    chklen(25, 4);
    r8(4'h6, 8'h92);
    chk({13'h0000, pos}, 16'h0005);
    r8(4'h4, 8'hA7);
    r8(4'h5, 8'h02);
    w8(4'h7, 8'h25);
    r8(4'h4, 8'hC0);
    r8(4'h5, 8'hA9);
    chk({15'h0000, smp}, 16'h0000);
    w8(4'h6, 8'h82);
    r8(4'h6, 8'h92);
    w8(4'h6, 8'h92);
    r8(4'h6, 8'h82);
    $display("test conversion done");
    w8(4'h7, 8'h05);
    val <= 10'h155;
    w8(4'h6, 8'hC2);
    waitdone();
    chklen(13, 4);
    r8(4'h4, 8'h55);
    val <= 10'h3FF;
    w8(4'h6, 8'hC0);
    waitdone();
    chklen(13, 2);
    r8(4'h6, 8'h90);
    r8(4'h5, 8'h01);
    $display("test lock done");
    w8(4'hC, 8'h01);
    w8(4'h6, 8'h8A);
    pause(3);
    chk({15'h0000, irq}, 16'h0001);
    w8(4'hC, 8'h00);
    pause(3);
    chk({15'h0000, irq}, 16'h0000);
    r8(4'h9, 8'h01);
    w8(4'hA, 8'h01);
    pause(3);
    chk({15'h0000, irq}, 16'h0001);
    w8(4'hA, 8'h00);
    pause(3);
    chk({15'h0000, irq}, 16'h0000);
    w8(4'hB, 8'h01);
    r8(4'h9, 8'h00);
    w8(4'hC, 8'h01);
    pause(3);
    chk({15'h0000, irq}, 16'h0001);
    ack <= 1'b1;
    pause(1);
    ack <= 1'b0;
    pause(3);
    chk({15'h0000, irq}, 16'h0000);
    r8(4'h6, 8'h8A);
    $display("test interrupt done");
    w8(4'h6, 8'hC2);
    pause(10);
    w8(4'h6, 8'h02);
    pause(3);
    chk({13'h0000, smp, pwr, cclk}, 16'h0000);
    r8(4'h6, 8'h02);
    $display("test abort done");
    w8(4'h8, 8'h01);
    w8(4'h6, 8'hA2);
    trig <= 8'h04;
    pause(20);
    chk({15'h0000, smp}, 16'h0000);
    trig <= 8'h02;
    waitdone();
    chklen(25, 4);
    r8(4'h6, 8'hB2);
    trig <= 8'h00;
    $display("test trigger done");
    w8(4'h8, 8'h00);
    w8(4'hB, 8'h01);
    w8(4'hA, 8'h01);
    w8(4'h6, 8'hF2);
    waitirq();
    w8(4'hB, 8'h01);
    pause(2);
    waitirq();
    r8(4'h9, 8'h01);
    w8(4'h6, 8'h12);
    pause(3);
    chk({15'h0000, smp}, 16'h0000);
    $display("test free run done");
    summarize();
  end
endmodule
`default_nettype wire
